// ### verif/prs_analog_model.sv
// Purpose: Analog front end beside the sequencer: the shared comparator and its two inputs.
// Assumes: Pin voltages come from the bench in mV and change away from clock edges.
// Notes: The result changes at once; the sequencer synchronises it itself.
`timescale 1ns/1ps
module prs_analog_model (
  // Control from the sequencer
  input  wire logic        cmp_sel_i,
  input  wire logic        sd_thr_run_i,
  // Pin voltages in mV
  input  wire logic [15:0] cfg_mv_i,
  input  wire logic [15:0] temp_mv_i,
  // Shared comparator result
  output logic             cmp_out_o
);
  // ==========================================
  // Shared comparator
  // A hot thermistor pulls its pin low, so that side trips below the threshold.
  assign cmp_out_o = cmp_sel_i ? (temp_mv_i < (sd_thr_run_i ? 16'h03e8 : 16'h04b0))
                               : (cfg_mv_i > 16'h03f7);
endmodule // prs_analog_model

// ### verif/prs_seq_test.sv
// Purpose: Self-checking bench of the protection sequencer.
// Assumes: Zero-wait APB slave and 40-cycle start, as handed over.
// Notes: Strobes are spaced so synchronised levels settle before use.
`timescale 1ns/1ps
module prs_seq_test;
  // ==========================================
  // Stimulus and observed signals
  logic        clk        = 1'b0;
  logic        resetn     = 1'b0;
  logic        ce         = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        strobe     = 1'b0;
  logic        sense_over = 1'b0;
  logic        pin_open   = 1'b0;
  logic        cfg_float  = 1'b0;
  logic [2:0]  cfg_meas   = 3'h0;
  logic        restart    = 1'b0;
  logic        latch_rel  = 1'b0;
  logic [15:0] cfg_mv     = 16'h01f4;
  logic [15:0] temp_mv    = 16'h0514;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, cmp_out;
  logic        gate_en, cmp_sel, thr_run, shutdown, latched;
  logic [2:0]  level;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [8:0]  comp_mv [5] = '{9'h000, 9'h04b, 9'h096, 9'h12c, 9'h1c2};
  logic [10:0] thr_mv [5]  = '{11'h72e, 11'h745, 11'h75c, 11'h78a, 11'h7b8};

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  prs_seq u_prs_seq (
    .clk_i(clk), .resetn_i(resetn), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cycle_strobe_i(strobe), .cmp_out_i(cmp_out), .sense_ovp_i(sense_over),
    .sd_open_i(pin_open), .cfg_float_i(cfg_float), .cfg_meas_i(cfg_meas),
    .restart_i(restart), .latch_release_i(latch_rel),
    .gate_en_o(gate_en), .cmp_sel_o(cmp_sel), .sd_thr_run_o(thr_run),
    .cdc_level_o(level), .shutdown_o(shutdown), .latched_o(latched)
  );

  prs_analog_model u_prs_analog_model (
    .cmp_sel_i(cmp_sel), .sd_thr_run_i(thr_run), .cfg_mv_i(cfg_mv),
    .temp_mv_i(temp_mv), .cmp_out_o(cmp_out)
  );

  // ==========================================
  // Shared tasks
  // Compares with case equality so an unknown never passes.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high, however long that takes.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One switching cycle; three idle cycles first let the synchronisers settle.
  task automatic step();
    repeat (3) @(posedge clk);
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // A supply recycle, long enough to pass the synchroniser.
  task automatic kick();
    restart <= 1'b1;
    repeat (6) @(posedge clk);
    restart <= 1'b0;
  endtask

  // Waits, bounded, for the gate drive to be allowed.
  task automatic wait_gate();
    int n = 0;
    while (gate_en !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk);
    end
    chk("gate_en", gate_en, 1);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("state reset", rd[2:0], 3'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
  endtask

  task automatic t_start_fail();
    temp_mv <= 16'h044c;
    apb(1'b1, 8'h00, 32'h1);
    repeat (60) @(posedge clk);
    chk("start shutdown", shutdown, 1'b1);
    chk("start gate", gate_en, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk("start cause", rd[9], 1'b1);
    temp_mv <= 16'h0514;
  endtask

  // Every level, then an external trip whose count is broken once by a clean cycle.
  task automatic t_levels();
    for (int lv = 0; lv < 5; lv++)
    begin
      cfg_meas <= 3'(lv);
      kick();
      repeat (24) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk("setup state", rd[2:0], 3'h2);
      chk("setup gate", gate_en, 1'b0);
      wait_gate();
      chk("level", level, lv);
      apb(1'b0, 8'h08, 32'h0);
      chk("comp mv", rd[8:0], comp_mv[lv]);
      chk("sense thr", rd[26:16], thr_mv[lv]);
      cfg_meas <= 3'(4 - lv);
      for (int i = 0; i < 6; i++)
      begin
        cfg_mv <= (i == 2) ? 16'h01f4 : 16'h044c;
        step();
        if (i < 5) chk("level kept", level, lv);
        chk("cfg trip", shutdown, i == 5);
      end
      cfg_mv <= 16'h01f4;
    end
  endtask

  // Two over samples late in one OV window must still count in the next OV window.
  task automatic t_windows();
    kick();
    wait_gate();
    chk("run thr", thr_run, 1'b1);
    temp_mv <= 16'h044c;
    for (int k = 1; k < 18; k++)
    begin
      cfg_mv <= (k == 7 || k == 8 || k == 17) ? 16'h044c : 16'h01f4;
      step();
      if (k < 17) chk("window", cmp_sel, (k / 8) % 2);
      chk("kept count", shutdown, k == 17);
    end
    cfg_mv <= 16'h01f4;
    temp_mv <= 16'h0514;
  endtask

  task automatic t_ot();
    kick();
    wait_gate();
    for (int k = 1; k < 12; k++)
    begin
      temp_mv <= (k > 8) ? 16'h0384 : 16'h0514;
      step();
      chk("temp trip", shutdown, k == 11);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("temp cause", rd[6], 1'b1);
    temp_mv <= 16'h0514;
  endtask

  task automatic t_latch();
    apb(1'b1, 8'h00, 32'h3);
    kick();
    wait_gate();
    sense_over <= 1'b1;
    step();
    sense_over <= 1'b0;
    chk("latched", latched, 1'b1);
    kick();
    repeat (60) @(posedge clk);
    chk("still latched", latched, 1'b1);
    chk("latched gate", gate_en, 1'b0);
    latch_rel <= 1'b1;
    repeat (6) @(posedge clk);
    latch_rel <= 1'b0;
    wait_gate();
    apb(1'b1, 8'h00, 32'h1);
  endtask

  // An open sensing pin must never trip; a floating config pin must.
  task automatic t_pins();
    pin_open <= 1'b1;
    temp_mv <= 16'h0000;
    repeat (16) step();
    chk("open pin", shutdown, 1'b0);
    sense_over <= 1'b1;
    step();
    sense_over <= 1'b0;
    chk("sense trip", shutdown, 1'b1);
    cfg_float <= 1'b1;
    kick();
    repeat (60) @(posedge clk);
    chk("float off", shutdown, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("float cause", rd[8], 1'b1);
    chk("open start", rd[9], 1'b0);
    // A low enable freezes the synchronisers too, so a recycle during it is missed.
    ce <= 1'b0;
    kick();
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk("frozen", shutdown, 1'b1);
  endtask

  // ==========================================
  // Verdict
  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Reset for eight cycles, then the scenarios in order.
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_start_fail();
    t_levels();
    t_windows();
    t_ot();
    t_latch();
    t_pins();
    finish_test();
  end

  // The run needs some 1200 cycles; over sixteen times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule // prs_seq_test

// ### verilog/prs_fault_cnt.sv
// Purpose: Consecutive-cycle fault counter for one protection.
// Assumes: step_i is a one-cycle pulse per sampled switching cycle.
// Notes: trip_o is combinational and marks the confirming cycle.
`timescale 1ns/1ps
`include "prs_regs.svh"
module prs_fault_cnt #(
  parameter logic [2:0] COUNT = 3'(`PRS_FAULT_CNT)
) (
  // Clock, reset, enable
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  // Control
  input  wire logic clr_i,
  input  wire logic step_i,
  input  wire logic hit_i,
  output logic      trip_o
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;

  // ==========================================================
  // A clean sampled cycle restarts the count; unsampled cycles leave it alone.
  assign trip_o   = step_i && hit_i && (cnt_reg == COUNT - 3'h1);
  assign cnt_next = clr_i ? 3'h0 :
                    !step_i ? cnt_reg :
                    !hit_i ? 3'h0 :
                    trip_o ? 3'h0 : cnt_reg + 3'h1;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_reg <= 3'h0;
    else if (ce_i)
      cnt_reg <= cnt_next;
  end
endmodule // prs_fault_cnt

// ### verilog/prs_pkg.sv
// Purpose: Types shared by the protection sequencer files.
// Assumes: Nothing beyond the register header.
// Notes: Codes of the state type are exposed in the status register.
package prs_pkg;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    PRS_IDLE      = 3'b000,
    PRS_OTP_CHECK = 3'b001,
    PRS_CDC_CFG   = 3'b010,
    PRS_RUN       = 3'b011,
    PRS_FAULT_OFF = 3'b100,
    PRS_LATCHED   = 3'b101
  } prs_state_type;
endpackage

// ### verilog/prs_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the protection sequencer.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Definitions only.
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
// ==========================================================
// Register map
`define PRS_CTRL_OFF      8'h00
`define PRS_STATUS_OFF    8'h04
`define PRS_CDC_INFO_OFF  8'h08
`define PRS_CTRL_RST      2'h0
// ==========================================================
// Field positions
`define PRS_CTRL_ENABLE   0
`define PRS_CTRL_LATCH    1
`define PRS_ST_WINDOW     3
`define PRS_ST_LATCHED    4
`define PRS_ST_CAUSE_LSB  5
`define PRS_ST_CDC_LSB    10
`define PRS_INFO_THR_LSB  16
// ==========================================================
// Timing
`define PRS_CLK_NS        10
`define PRS_SETTLE_NS     200
`define PRS_SETTLE_CYC    ((`PRS_SETTLE_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
`define PRS_WIN_CYCLES    8
`define PRS_FAULT_CNT     3
// ==========================================================
// Compensation in mV and sense-winding trip level in mV per level
`define PRS_COMP_MV_L1    9'd0
`define PRS_COMP_MV_L2    9'd75
`define PRS_COMP_MV_L3    9'd150
`define PRS_COMP_MV_L4    9'd300
`define PRS_COMP_MV_L5    9'd450
`define PRS_THR_MV_L1     11'd1838
`define PRS_THR_MV_L2     11'd1861
`define PRS_THR_MV_L3     11'd1884
`define PRS_THR_MV_L4     11'd1930
`define PRS_THR_MV_L5     11'd1976
`define PRS_LEVEL_MAX     3'h4
`endif

// ### verilog/prs_seq.sv
// Purpose: Protection sequencer: start temperature check, compensation setup, shared OV/OT detection.
// Assumes: cycle_strobe_i pulses once per switching cycle at the output sampling instant.
// Notes: Analog comparator and classifier results arrive asynchronously and are synchronised.
//
// Summary of operation
// - In run, the detection window flips between OV and OT every eight cycles.
// - In the OV window the configuration pin drives the shared comparator input.
// - Configuration pin above 1.015V for consecutive samples raises the OV trip.
// - In the OT window, shutdown sense below 1.0V for consecutive cycles shuts down.
// - Before start, shutdown sense below 1.2V on a pin that is not open is a fault and start is refused.
// - A passing start check leads to compensation setup, then run.
// - In run the temperature threshold drops from 1.2V to 1.0V.
// - No gate pulses are issued during compensation setup.
// - Resistance class maps to five levels: 0, 75, 150, 300, 450 mV.
// - Sense-winding OV threshold follows level, 1.838V up to 1.976V.
// - A floating configuration pin at the end of compensation setup shuts the device down.
// - A grounded configuration pin selects level 1, no compensation.
// - An open shutdown sense pin disables the external OT check.
// - Both OV checks stay active; either one shuts down.
// - Compensation level is set only once per start.
// - When latching is on, no restart follows a latch even if cleared.
// - The latch releases only on the deep supply drop signal.
`timescale 1ns/1ps
`include "prs_regs.svh"
module prs_seq
  import prs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Switching timebase
  input  wire logic        cycle_strobe_i,
  // Analog results
  input  wire logic        cmp_out_i,
  input  wire logic        sense_ovp_i,
  input  wire logic        sd_open_i,
  input  wire logic        cfg_float_i,
  input  wire logic [2:0]  cfg_meas_i,
  input  wire logic        restart_i,
  input  wire logic        latch_release_i,
  // Power stage and analog control
  output logic             gate_en_o,
  output logic             cmp_sel_o,
  output logic             sd_thr_run_o,
  output logic [2:0]       cdc_level_o,
  output logic             shutdown_o,
  output logic             latched_o
);
  // ==========================================================
  // Synchronised analog levels
  logic [8:0] sync_q;
  logic       cmp_s;
  logic       sense_s;
  logic       open_s;
  logic       float_s;
  logic       restart_s;
  logic       release_s;
  logic [2:0] meas_s;

  prs_sync #(.WIDTH(9)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({cmp_out_i, sense_ovp_i, sd_open_i, cfg_float_i, restart_i, latch_release_i, cfg_meas_i}),
    .q_o      (sync_q)
  );

  assign {cmp_s, sense_s, open_s, float_s, restart_s, release_s, meas_s} = sync_q;

  // ==========================================================
  // State and control registers
  prs_state_type state_reg;
  prs_state_type state_next;
  logic [1:0]    ctrl_reg;
  logic [4:0]    settle_reg;
  logic [2:0]    win_cnt_reg;
  logic          win_reg;
  logic          win_next;
  logic [2:0]    cdc_reg;
  logic [4:0]    cause_reg;
  logic [4:0]    cause_set;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic          gate_reg;
  logic          sel_reg;
  logic          thr_reg;
  logic          shut_reg;
  logic          latched_reg;

  // ==========================================================
  // Decode of common conditions.
  wire in_run      = (state_reg == PRS_RUN);
  wire settle_done = (settle_reg == 5'(`PRS_SETTLE_CYC - 1));
  wire run_strobe  = in_run && cycle_strobe_i;
  wire win_wrap    = (win_cnt_reg == 3'(`PRS_WIN_CYCLES - 1));
  wire ov_step     = run_strobe && !win_reg;
  wire ot_step     = run_strobe && win_reg && !open_s;
  wire ov_trip;
  wire ot_trip;
  wire sense_trip  = run_strobe && sense_s;
  wire any_trip    = ov_trip || ot_trip || sense_trip;
  wire start_bad   = settle_done && cmp_s && !open_s;
  wire [2:0] level_sel = (meas_s > `PRS_LEVEL_MAX) ? `PRS_LEVEL_MAX : meas_s;

  // Separate counters, each stepping only inside its own window, so counts carry over.
  prs_fault_cnt u_ov_cnt (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .clr_i    (state_reg == PRS_IDLE),
    .step_i   (ov_step),
    .hit_i    (cmp_s),
    .trip_o   (ov_trip)
  );

  prs_fault_cnt u_ot_cnt (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .clr_i    (state_reg == PRS_IDLE),
    .step_i   (ot_step),
    .hit_i    (cmp_s),
    .trip_o   (ot_trip)
  );

  // ==========================================================
  // Sequencer transitions.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PRS_IDLE:
        if (ctrl_reg[`PRS_CTRL_ENABLE])
          state_next = PRS_OTP_CHECK;
      PRS_OTP_CHECK:
        if (start_bad)
          state_next = PRS_FAULT_OFF;
        else if (settle_done)
          state_next = PRS_CDC_CFG;
      PRS_CDC_CFG:
        if (settle_done && float_s)
          state_next = PRS_FAULT_OFF;
        else if (settle_done)
          state_next = PRS_RUN;
      PRS_RUN:
        if (any_trip)
          state_next = ctrl_reg[`PRS_CTRL_LATCH] ? PRS_LATCHED : PRS_FAULT_OFF;
      PRS_FAULT_OFF:
        if (restart_s)
          state_next = PRS_IDLE;
      PRS_LATCHED:
        if (release_s)
          state_next = PRS_IDLE;
      default:
        state_next = PRS_IDLE;
    endcase
  end

  // The window flips on the eighth sampled cycle and starts in OV on every entry to run.
  assign win_next = in_run ? (run_strobe && win_wrap ? !win_reg : win_reg) : 1'b0;

  // Fault causes: OV ext, OT ext, sense OV, float, start OT.
  assign cause_set = {start_bad && state_reg == PRS_OTP_CHECK,
                      settle_done && float_s && state_reg == PRS_CDC_CFG,
                      sense_trip, ot_trip, ov_trip};

  // ==========================================================
  // Sequencer registers. Outputs follow the next state so they line up with it.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg   <= PRS_IDLE;
      settle_reg  <= 5'h00;
      win_reg     <= 1'b0;
      win_cnt_reg <= 3'h0;
      gate_reg    <= 1'b0;
      sel_reg     <= 1'b1;
      thr_reg     <= 1'b0;
      shut_reg    <= 1'b0;
      latched_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg   <= state_next;
      settle_reg  <= (state_next != state_reg) ? 5'h00 : settle_reg + 5'h01;
      win_reg     <= win_next;
      win_cnt_reg <= !in_run ? 3'h0 : run_strobe ? win_cnt_reg + 3'h1 : win_cnt_reg;
      gate_reg    <= (state_next == PRS_RUN);
      sel_reg     <= (state_next == PRS_RUN) ? win_next : 1'b1;
      thr_reg     <= (state_next == PRS_RUN);
      shut_reg    <= (state_next == PRS_FAULT_OFF) || (state_next == PRS_LATCHED);
      latched_reg <= (state_next == PRS_LATCHED);
    end
  end

  // Level and causes. Causes clear on a new start; a set in the same cycle still wins.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cdc_reg   <= 3'h0;
      cause_reg <= 5'h00;
    end
    else if (ce_i)
    begin
      if (state_reg == PRS_CDC_CFG && state_next == PRS_RUN)
        cdc_reg <= level_sel;
      cause_reg <= ((state_reg == PRS_IDLE && state_next == PRS_OTP_CHECK) ? 5'h00 : cause_reg) | cause_set;
    end
  end

  // ==========================================================
  // Level tables for compensation and sense-winding OV threshold.
  function automatic logic [8:0] comp_mv(input logic [2:0] lvl);
    case (lvl)
      3'h0:    comp_mv = `PRS_COMP_MV_L1;
      3'h1:    comp_mv = `PRS_COMP_MV_L2;
      3'h2:    comp_mv = `PRS_COMP_MV_L3;
      3'h3:    comp_mv = `PRS_COMP_MV_L4;
      default: comp_mv = `PRS_COMP_MV_L5;
    endcase
  endfunction

  function automatic logic [10:0] thr_mv(input logic [2:0] lvl);
    case (lvl)
      3'h0:    thr_mv = `PRS_THR_MV_L1;
      3'h1:    thr_mv = `PRS_THR_MV_L2;
      3'h2:    thr_mv = `PRS_THR_MV_L3;
      3'h3:    thr_mv = `PRS_THR_MV_L4;
      default: thr_mv = `PRS_THR_MV_L5;
    endcase
  endfunction

  // ==========================================================
  // APB decode. Read data is prepared in setup so the access phase ends at once.
  wire        setup     = psel_i && !penable_i;
  wire        wr_fire   = psel_i && penable_i && pwrite_i && pready_reg;
  wire        hit_ctrl  = (paddr_i == `PRS_CTRL_OFF);
  wire        hit_stat  = (paddr_i == `PRS_STATUS_OFF);
  wire        hit_info  = (paddr_i == `PRS_CDC_INFO_OFF);
  wire        mapped    = hit_ctrl || hit_stat || hit_info;
  wire [31:0] ctrl_rd   = {30'h0, ctrl_reg};
  wire [31:0] stat_rd   = {19'h0, cdc_reg, cause_reg, latched_reg, win_reg, state_reg};
  wire [31:0] info_rd   = {5'h00, thr_mv(cdc_reg), 7'h00, comp_mv(cdc_reg)};
  wire [31:0] rd_mux    = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : hit_info ? info_rd : 32'h0;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_reg    <= `PRS_CTRL_RST;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg  <= (setup && !pwrite_i) ? rd_mux : 32'h0;
      if (wr_fire && hit_ctrl)
        ctrl_reg <= pwdata_i[1:0];
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops.
  assign prdata_o     = prdata_reg;
  assign pready_o     = pready_reg;
  assign pslverr_o    = pslverr_reg;
  assign gate_en_o    = gate_reg;
  assign cmp_sel_o    = sel_reg;
  assign sd_thr_run_o = thr_reg;
  assign cdc_level_o  = cdc_reg;
  assign shutdown_o   = shut_reg;
  assign latched_o    = latched_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_cfg_float;
    ce_i && state_reg == PRS_CDC_CFG && settle_done && float_s;
  endsequence

  chk_gate_off_cfg: assert property (state_reg == PRS_CDC_CFG |-> !gate_en_o)
    else $error("gate driven during compensation setup");
  chk_window_flip: assert property (ce_i && run_strobe && win_wrap && state_next == PRS_RUN |=> win_reg != $past(win_reg))
    else $error("window did not flip after eight cycles");
  chk_ov_mux_route: assert property (in_run && !win_reg |-> !cmp_sel_o)
    else $error("configuration pin not routed in OV window");
  chk_ov_trip_off: assert property (ce_i && in_run && ov_trip |=> shutdown_o && !gate_en_o)
    else $error("OV trip did not shut down");
  chk_ot_trip_off: assert property (ce_i && in_run && ot_trip |=> shutdown_o)
    else $error("OT trip did not shut down");
  chk_start_otp: assert property (ce_i && state_reg == PRS_OTP_CHECK && start_bad |=> state_reg == PRS_FAULT_OFF)
    else $error("start refused check failed");
  chk_run_thresh: assert property (in_run |-> sd_thr_run_o)
    else $error("run threshold not selected");
  chk_float_off: assert property (s_cfg_float |=> shutdown_o ##0 !gate_en_o)
    else $error("floating pin did not shut down");
  chk_level_once: assert property (state_reg != PRS_CDC_CFG |=> $stable(cdc_level_o))
    else $error("level changed outside setup");
  chk_latch_hold: assert property (state_reg == PRS_LATCHED && !release_s |=> latched_o)
    else $error("latch left without release");
  // Watched through the shutdown output so a broken gate of the OT count is caught.
  chk_open_no_ot: assert property (ce_i && in_run && win_reg && open_s && !sense_s |=> !shutdown_o)
    else $error("OT trip with open pin");
endmodule // prs_seq

// ### verilog/prs_sync.sv
// Purpose: Two-flop synchroniser for a vector of slow, independent levels.
// Assumes: Each bit is a level that stays put for many clock cycles.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module prs_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  // Levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ==========================================================
  // Two stages, frozen while the enable is low.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else if (ce_i)
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // prs_sync
